/* File: rtl/scbt_pkg.sv */
// Shared constants and types of the serial control bus target.
// Assumes a single 100 MHz core clock; all bus pins arrive asynchronously.
package scbt_pkg;
   // Register offsets
   localparam logic [7:0] OFS_PRIMARY = 8'h00;
   localparam logic [7:0] OFS_GENCFG  = 8'h02;
   localparam logic [7:0] OFS_PORTSEL = 8'h4C;
   localparam logic [7:0] OFS_BCCFG   = 8'h58;
   localparam logic [7:0] OFS_ALIAS0  = 8'hF8;
   localparam logic [7:0] OFS_ALIAS1  = 8'hF9;
   // Field positions
   localparam int GENCFG_PROXY_BIT   = 5;
   localparam int BCC_FWD_BIT        = 6;
   localparam int BCC_RATE_MSB       = 2;
   localparam int PORTSEL_RDPORT_BIT = 4;
   localparam int PORTSEL_WR0_BIT    = 0;
   localparam int PORTSEL_WR1_BIT    = 1;
   // Reset values
   localparam logic [7:0] RST_GENCFG  = 8'h00;
   localparam logic [7:0] RST_PORTSEL = 8'h01;
   localparam logic [7:0] RST_BCCFG   = 8'h00;
   localparam logic [7:0] RST_ALIAS   = 8'h00;
   // Address strap decode
   localparam logic [6:0] STRAP_BASE_ADDR = 7'h30;
   localparam logic [6:0] STRAP_STEP      = 7'h02;
   localparam logic [6:0] STRAP_TOP_ADDR  = 7'h3D;
   localparam logic [2:0] STRAP_TOP_CODE  = 3'h7;
   // Back channel rate codes; zero follows the mode strap
   localparam logic [2:0] RATE_STRAP = 3'h0;
   localparam logic [2:0] RATE_2P5M  = 3'h1;
   localparam logic [2:0] RATE_50M   = 3'h2;
   // Timing
   localparam int CLK_FREQ_HZ    = 100_000_000;
   localparam int STRAP_DELAY_MS = 1;
   localparam int STRAP_WAIT_DEF = STRAP_DELAY_MS * (CLK_FREQ_HZ / 1000);
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int NUM_PORTS = 2;

   typedef enum logic [1:0] {RMT_ADDR, RMT_WRITE, RMT_READ, RMT_STOP} scbt_rkind_t;
   typedef struct packed {
      scbt_rkind_t kind;
      logic        port;
      logic        restart;
      logic [7:0]  data;
   } scbt_rreq_t;
   typedef struct packed {
      logic       ack;
      logic [7:0] data;
   } scbt_rrsp_t;
   typedef struct packed {
      logic       proxyEn;
      logic [1:0] gpio;
      logic [7:0] caps;
   } scbt_sideband_t;

   function automatic logic [6:0] strap_address(input logic [2:0] code);
      if (code == STRAP_TOP_CODE) begin
         strap_address = STRAP_TOP_ADDR;
      end else begin
         strap_address = 7'(STRAP_BASE_ADDR + STRAP_STEP * 7'(code));
      end
   endfunction : strap_address
endpackage : scbt_pkg

/* File: rtl/scbt_target.sv */
// Two-wire control bus target with back channel forwarding for two ports.
// Assumes SCL, SDA and straps are asynchronous pins; the back channel link
// logic runs on clk and answers each forwarded byte with one response pulse.
// Functional notes
// - Target for standard, fast, fast-plus up to 1 MHz
// - Never stretch SCL for local register access
// - Stretch SCL until remote response returns
// - Forward combined format including repeated start
// - Proxy enable bit makes device bus controller
// - Back channel carries GPIO and capabilities
// - Strap sets rate, per-port field overrides
// - Rates 50 Mbps and 2.5 Mbps supported
// - Sample address strap 1 ms after release
// - Primary address held in register zero
// - Strap code picks one of eight addresses
// - Two port addresses reach own port registers
// - Port addresses also reach shared registers
// - Port aliases live at 0xF8 and 0xF9
// - Forward remote only while forward bit set
// - Forward only recognized serializer or target aliases
module scbt_target import scbt_pkg::*; #(
   parameter int         STRAP_WAIT_CYCLES = STRAP_WAIT_DEF,
   parameter int         NUM_ALIAS         = 8,
   parameter logic [7:0] CAPABILITIES      = 8'h5A  // Arbitrary value
) (
   // Clock and reset (reset is the power-down pin, inverted)
   input  wire logic                                 clk,
   input  wire logic                                 rst,
   // Bus pins
   input  wire logic                                 sclIn,
   output logic                                      sclOut,
   output logic                                      sclOe,
   input  wire logic                                 sdaIn,
   output logic                                      sdaOut,
   output logic                                      sdaOe,
   // Straps and port status
   input  wire logic [2:0]                           addressStrapPin,
   input  wire logic                                 modeStrapPin,
   input  wire logic [NUM_PORTS-1:0]                 rxLock,
   input  wire logic [1:0]                           gpioIn,
   // Alias tables per port
   input  wire logic [NUM_PORTS-1:0][6:0]            serializerAlias,
   input  wire logic [NUM_PORTS-1:0][NUM_ALIAS-1:0][6:0] targetAlias,
   // Back channel link
   output scbt_rreq_t                                rmtReq,
   output logic                                      rmtReqValid,
   input  wire scbt_rrsp_t                           rmtRsp,
   input  wire logic                                 rmtRspValid,
   output logic [NUM_PORTS-1:0][2:0]                 bcRate,
   output scbt_sideband_t                            sideband
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_RX, ST_ACK_OUT, ST_TX, ST_ACK_IN, ST_WAIT
   } scbt_state_t;
   localparam int PIN_W = 10;
   // Bus wires reset to their released level so no false edge follows reset
   localparam logic [PIN_W-1:0] PIN_IDLE = {2'h3, {(PIN_W-2){1'b0}}};
   localparam int CNT_W = $clog2(STRAP_WAIT_CYCLES + 1);
   localparam logic [CNT_W-1:0] STRAP_LAST = CNT_W'(STRAP_WAIT_CYCLES - 1);

   logic [PIN_W-1:0] pinMeta, pinSync;
   logic             sclQ, sdaQ;
   logic             sclS, sdaS, modeS;
   logic [2:0]       strapS;
   logic [1:0]       lockS, gpioS;

   scbt_state_t      state, next_state;
   logic [3:0]       bitCnt, next_bitCnt;
   logic [7:0]       shift, next_shift;
   logic             isRead, next_isRead, isRemote, next_isRemote;
   logic             viaAlias, next_viaAlias, aliasPort, next_aliasPort;
   logic             waitRead, next_waitRead, rmtActive, next_rmtActive;
   logic [7:0]       ptr, next_ptr;
   logic             ptrValid, next_ptrValid;
   logic             next_sdaOe, next_sclOe, next_rmtReqValid;
   scbt_rreq_t       next_rmtReq;
   logic             strapDone, next_strapDone, modeDefault, next_modeDefault;
   logic [CNT_W-1:0] strapCnt, next_strapCnt;
   logic [7:0]       primaryAddr, next_primaryAddr, genCfg, next_genCfg;
   logic [7:0]       portSel, next_portSel;
   logic [NUM_PORTS-1:0][7:0] bcCfg, next_bcCfg, aliasReg, next_aliasReg;
   logic [NUM_PORTS-1:0][2:0] next_bcRate;
   scbt_sideband_t   next_sideband;

   logic             startEv, stopEv, sclRise, sclFall;
   logic             localHit, remoteHit, selPort, rdPort;
   logic [NUM_PORTS-1:0] portIdHit, rmtKnown;
   logic [NUM_PORTS-1:0][NUM_ALIAS-1:0] tgtHit;

   // Pins pass two flops; only the second stage is read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinMeta <= PIN_IDLE;
         pinSync <= PIN_IDLE;
         sclQ    <= 1'b1;
         sdaQ    <= 1'b1;
      end else begin
         pinMeta <= {sclIn, sdaIn, addressStrapPin, modeStrapPin, rxLock, gpioIn};
         pinSync <= pinMeta;
         sclQ    <= sclS;
         sdaQ    <= sdaS;
      end
   end
   assign {sclS, sdaS, strapS, modeS, lockS, gpioS} = pinSync;

   // At 100 MHz a 1 MHz SCL still gives 50 samples per phase
   assign sclRise = sclS && !sclQ;
   assign sclFall = !sclS && sclQ;
   assign startEv = sclS && sclQ && sdaQ && !sdaS;
   assign stopEv  = sclS && sclQ && !sdaQ && sdaS;

   assign selPort = portSel[PORTSEL_RDPORT_BIT];
   assign rdPort  = viaAlias ? aliasPort : selPort;
   genvar gp, gi;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
         assign portIdHit[gp] = (aliasReg[gp][7:1] != 7'h00) &&
                                (aliasReg[gp][7:1] == shift[7:1]);
         for (gi = 0; gi < NUM_ALIAS; gi++) begin : g_ent
            assign tgtHit[gp][gi] = (targetAlias[gp][gi] != 7'h00) &&
                                    (targetAlias[gp][gi] == shift[7:1]);
         end
         assign rmtKnown[gp] = (serializerAlias[gp] == shift[7:1]) || (|tgtHit[gp]);
      end
   endgenerate
   assign localHit  = strapDone && ((primaryAddr[7:1] == shift[7:1]) || (|portIdHit));
   // Unlocked ports refuse forwarding rather than hang the stretch
   assign remoteHit = strapDone && bcCfg[selPort][BCC_FWD_BIT] && lockS[selPort]
                      && rmtKnown[selPort];

   function automatic logic [7:0] reg_read(input logic [7:0] a, input logic p);
      case (a)
         OFS_PRIMARY: reg_read = primaryAddr;
         OFS_GENCFG:  reg_read = genCfg;
         OFS_PORTSEL: reg_read = portSel;
         OFS_BCCFG:   reg_read = bcCfg[p];
         OFS_ALIAS0:  reg_read = aliasReg[0];
         OFS_ALIAS1:  reg_read = aliasReg[1];
         default:     reg_read = 8'h00;
      endcase
   endfunction : reg_read

   always_comb begin
      next_state       = state;
      next_bitCnt      = bitCnt;
      next_shift       = shift;
      next_isRead      = isRead;
      next_isRemote    = isRemote;
      next_viaAlias    = viaAlias;
      next_aliasPort   = aliasPort;
      next_waitRead    = waitRead;
      next_rmtActive   = rmtActive;
      next_ptr         = ptr;
      next_ptrValid    = ptrValid;
      next_sdaOe       = sdaOe;
      next_sclOe       = sclOe;
      next_rmtReqValid = 1'b0;
      next_rmtReq      = rmtReq;
      next_strapDone   = strapDone;
      next_strapCnt    = strapCnt;
      next_modeDefault = modeDefault;
      next_primaryAddr = primaryAddr;
      next_genCfg      = genCfg;
      next_portSel     = portSel;
      next_bcCfg       = bcCfg;
      next_aliasReg    = aliasReg;
      if (!strapDone) begin
         if (strapCnt == STRAP_LAST) begin
            next_strapDone   = 1'b1;
            next_primaryAddr = {strap_address(strapS), 1'b0};
            next_modeDefault = modeS;
         end else begin
            next_strapCnt = strapCnt + 1'b1;
         end
      end
      if (startEv) begin
         next_state      = ST_ADDR;
         next_bitCnt     = 4'h0;
         next_sdaOe      = 1'b0;
         next_rmtReq.restart = rmtActive;
      end else if (stopEv) begin
         next_state = ST_IDLE;
         next_sdaOe = 1'b0;
         if (rmtActive) begin
            next_rmtActive   = 1'b0;
            next_rmtReqValid = 1'b1;
            next_rmtReq.kind = RMT_STOP;
         end
      end else begin
         case (state)
            ST_ADDR, ST_RX: begin
               if (sclRise && bitCnt != BYTE_BITS) begin
                  next_shift  = {shift[6:0], sdaS};
                  next_bitCnt = bitCnt + 1'b1;
               end
               if (sclFall && bitCnt == BYTE_BITS) begin
                  next_bitCnt = 4'h0;
                  if (state == ST_ADDR) begin
                     next_isRead = shift[0];
                     if (localHit) begin
                        next_isRemote  = 1'b0;
                        next_viaAlias  = |portIdHit;
                        next_aliasPort = portIdHit[1];
                        next_ptrValid  = shift[0] ? ptrValid : 1'b0;
                        next_sdaOe     = 1'b1;
                        next_state     = ST_ACK_OUT;
                     end else if (remoteHit) begin
                        next_isRemote    = 1'b1;
                        next_rmtActive   = 1'b1;
                        next_rmtReqValid = 1'b1;
                        next_rmtReq.kind = RMT_ADDR;
                        next_rmtReq.port = selPort;
                        next_rmtReq.data = shift;
                        next_waitRead    = 1'b0;
                        next_sclOe       = 1'b1;
                        next_state       = ST_WAIT;
                     end else begin
                        next_state = ST_IDLE;
                     end
                  end else if (isRemote) begin
                     next_rmtReqValid = 1'b1;
                     next_rmtReq.kind = RMT_WRITE;
                     next_rmtReq.restart = 1'b0;
                     next_rmtReq.data = shift;
                     next_waitRead    = 1'b0;
                     next_sclOe       = 1'b1;
                     next_state       = ST_WAIT;
                  end else begin
                     if (!ptrValid) begin
                        next_ptr      = shift;
                        next_ptrValid = 1'b1;
                     end else begin
                        next_ptr = ptr + 8'h01;
                        case (ptr)
                           OFS_PRIMARY: next_primaryAddr = shift;
                           OFS_GENCFG:  next_genCfg = shift;
                           OFS_PORTSEL: next_portSel = shift;
                           OFS_ALIAS0:  next_aliasReg[0] = shift;
                           OFS_ALIAS1:  next_aliasReg[1] = shift;
                           OFS_BCCFG: begin
                              // Port address pages its own port; else write-enable bits
                              if (viaAlias) begin
                                 next_bcCfg[aliasPort] = shift;
                              end else begin
                                 if (portSel[PORTSEL_WR0_BIT]) next_bcCfg[0] = shift;
                                 if (portSel[PORTSEL_WR1_BIT]) next_bcCfg[1] = shift;
                              end
                           end
                           default: ;
                        endcase
                     end
                     next_sdaOe = 1'b1;
                     next_state = ST_ACK_OUT;
                  end
               end
            end
            ST_ACK_OUT, ST_ACK_IN: begin
               if (state == ST_ACK_IN && sclRise && sdaS) begin
                  next_state = ST_IDLE;
               end else if (sclFall) begin
                  next_bitCnt = 4'h0;
                  if (!isRead) begin
                     next_sdaOe = 1'b0;
                     next_state = ST_RX;
                  end else if (isRemote) begin
                     next_sdaOe       = 1'b0;
                     next_rmtReqValid = 1'b1;
                     next_rmtReq.kind = RMT_READ;
                     next_rmtReq.restart = 1'b0;
                     next_waitRead    = 1'b1;
                     next_sclOe       = 1'b1;
                     next_state       = ST_WAIT;
                  end else begin
                     next_shift = reg_read(ptr, rdPort);
                     next_sdaOe = ~next_shift[7];
                     next_ptr   = ptr + 8'h01;
                     next_state = ST_TX;
                  end
               end
            end
            ST_TX: begin
               if (sclRise) begin
                  next_bitCnt = bitCnt + 1'b1;
               end
               if (sclFall) begin
                  if (bitCnt == BYTE_BITS) begin
                     next_sdaOe = 1'b0;
                     next_state = ST_ACK_IN;
                  end else begin
                     next_shift = {shift[6:0], 1'b0};
                     next_sdaOe = ~shift[6];
                  end
               end
            end
            ST_WAIT: begin
               if (rmtRspValid) begin
                  next_sclOe  = 1'b0;
                  next_bitCnt = 4'h0;
                  if (waitRead) begin
                     next_shift = rmtRsp.data;
                     next_sdaOe = ~rmtRsp.data[7];
                     next_state = ST_TX;
                  end else if (rmtRsp.ack) begin
                     next_sdaOe = 1'b1;
                     next_state = ST_ACK_OUT;
                  end else begin
                     next_sdaOe = 1'b0;
                     next_state = ST_IDLE;
                  end
               end
            end
            default: next_state = ST_IDLE;
         endcase
      end
   end

   // Rate resolution and link sideband
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (bcCfg[p][BCC_RATE_MSB:0] != RATE_STRAP) begin
            next_bcRate[p] = bcCfg[p][BCC_RATE_MSB:0];
         end else begin
            next_bcRate[p] = modeDefault ? RATE_50M : RATE_2P5M;
         end
      end
      next_sideband.proxyEn = genCfg[GENCFG_PROXY_BIT];
      next_sideband.gpio    = gpioS;
      next_sideband.caps    = CAPABILITIES;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state       <= ST_IDLE;
         bitCnt      <= 4'h0;
         shift       <= 8'h00;
         isRead      <= 1'b0;
         isRemote    <= 1'b0;
         viaAlias    <= 1'b0;
         aliasPort   <= 1'b0;
         waitRead    <= 1'b0;
         rmtActive   <= 1'b0;
         ptr         <= 8'h00;
         ptrValid    <= 1'b0;
         sdaOe       <= 1'b0;
         sclOe       <= 1'b0;
         sdaOut      <= 1'b0;
         sclOut      <= 1'b0;
         rmtReqValid <= 1'b0;
         rmtReq      <= '0;
         strapDone   <= 1'b0;
         strapCnt    <= '0;
         modeDefault <= 1'b0;
         primaryAddr <= 8'h00;
         genCfg      <= RST_GENCFG;
         portSel     <= RST_PORTSEL;
         bcCfg       <= {NUM_PORTS{RST_BCCFG}};
         aliasReg    <= {NUM_PORTS{RST_ALIAS}};
         bcRate      <= {NUM_PORTS{RATE_2P5M}};
         sideband    <= '0;
      end else begin
         state       <= next_state;
         bitCnt      <= next_bitCnt;
         shift       <= next_shift;
         isRead      <= next_isRead;
         isRemote    <= next_isRemote;
         viaAlias    <= next_viaAlias;
         aliasPort   <= next_aliasPort;
         waitRead    <= next_waitRead;
         rmtActive   <= next_rmtActive;
         ptr         <= next_ptr;
         ptrValid    <= next_ptrValid;
         sdaOe       <= next_sdaOe;
         sclOe       <= next_sclOe;
         rmtReqValid <= next_rmtReqValid;
         rmtReq      <= next_rmtReq;
         strapDone   <= next_strapDone;
         strapCnt    <= next_strapCnt;
         modeDefault <= next_modeDefault;
         primaryAddr <= next_primaryAddr;
         genCfg      <= next_genCfg;
         portSel     <= next_portSel;
         bcCfg       <= next_bcCfg;
         aliasReg    <= next_aliasReg;
         bcRate      <= next_bcRate;
         sideband    <= next_sideband;
      end
   end

   property p_no_local_stretch;
      @(posedge clk) disable iff (rst) sclOe |-> isRemote;
   endproperty
   a_no_local_stretch: assert property (p_no_local_stretch) else $error("local stretch");
   property p_stretch_req;
      @(posedge clk) disable iff (rst) $rose(sclOe) |-> rmtReqValid && state == ST_WAIT;
   endproperty
   a_stretch_req: assert property (p_stretch_req) else $error("stretch without request");
   property p_hold_stretch;
      @(posedge clk) disable iff (rst) sclOe && !rmtRspValid |=> sclOe;
   endproperty
   a_hold_stretch: assert property (p_hold_stretch) else $error("stretch dropped early");
   property p_strap_time;
      @(posedge clk) disable iff (rst) $rose(strapDone) |-> $past(strapCnt) == STRAP_LAST;
   endproperty
   a_strap_time: assert property (p_strap_time) else $error("strap sampled off time");
   property p_strap_addr;
      @(posedge clk) disable iff (rst)
         $rose(strapDone) |-> primaryAddr[7:1] == strap_address($past(strapS));
   endproperty
   a_strap_addr: assert property (p_strap_addr) else $error("wrong primary address");
   property p_proxy;
      @(posedge clk) disable iff (rst)
         $changed(genCfg) |-> ##1 sideband.proxyEn == $past(genCfg[GENCFG_PROXY_BIT]);
   endproperty
   a_proxy: assert property (p_proxy) else $error("proxy enable not followed");
   property p_fwd_gate;
      @(posedge clk) disable iff (rst)
         rmtReqValid && rmtReq.kind == RMT_ADDR |-> bcCfg[rmtReq.port][BCC_FWD_BIT];
   endproperty
   a_fwd_gate: assert property (p_fwd_gate) else $error("forward while disabled");
   property p_idle_quiet;
      @(posedge clk) disable iff (rst) state == ST_IDLE |-> !sdaOe && !sclOe;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle");
   property p_rate;
      @(posedge clk) disable iff (rst)
         bcCfg[0][BCC_RATE_MSB:0] != RATE_STRAP |=> bcRate[0] == $past(bcCfg[0][BCC_RATE_MSB:0]);
   endproperty
   a_rate: assert property (p_rate) else $error("rate override not followed");
endmodule : scbt_target

/* File: test/scbt_host.sv */
// Host controller model on the two-wire control bus, 160 ns bus clock.
// Assumes the bench resolves both open-drain wires with pull-ups.
module scbt_host (
   // Core clock and resolved wires
   input  wire logic clk,
   input  wire logic sclWire,
   input  wire logic sdaWire,
   // Host drive, high means released
   output logic      scl,
   output logic      sda
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'h1;
      sda = 1'h1;
   end
   task automatic q();
      repeat (4) @(posedge clk);
   endtask : q
   task automatic bit_x(input logic b, output logic r);
      sda <= b;
      q();
      scl <= 1'h1;
      q();
      // Bounded wait so a stuck stretch ends in the bench timeout
      for (int i = 0; i < 20000 && !sclWire; i++) @(posedge clk);
      q();
      r = sdaWire;
      scl <= 1'h0;
      q();
   endtask : bit_x
   task automatic start();
      sda <= 1'h1;
      q();
      scl <= 1'h1;
      q();
      sda <= 1'h0;
      q();
      scl <= 1'h0;
      q();
   endtask : start
   // Closes a transfer; t_remote follows its remote write with a repeated start instead
   task automatic stop();
      sda <= 1'h0;
      q();
      scl <= 1'h1;
      q();
      sda <= 1'h1;
      q();
   endtask : stop
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(b[i], r);
      bit_x(1'h1, r);
      ack = !r;
   endtask : wr_byte
   task automatic rd_byte(input logic ackIt, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'h1, b[i]);
      bit_x(!ackIt, r);
   endtask : rd_byte
endmodule : scbt_host

/* File: test/serial_control_bus_target_tb.sv */
// Bench for the control bus target: host model on the pins and a link
// responder answering each forwarded byte after 30 cycles.
module serial_control_bus_target_tb;
   import scbt_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic                      clk, rst, hScl, hSda, sclOut, sclOe, sdaOut, sdaOe;
   logic                      rmtReqValid, rmtRspValid, sawStretch, sawStop;
   logic [2:0]                strap;
   logic [1:0]                lock;
   logic                      mode;
   logic [NUM_PORTS-1:0][2:0] bcRate;
   scbt_rreq_t                rmtReq, lastReq;
   scbt_sideband_t            sideband;
   scbt_rrsp_t                rmtRsp;
   int                        n_mismatch, comparisons, cycles, waitCnt;
   wire                       sclW = hScl & (sclOe ? sclOut : 1'h1);
   wire                       sdaW = hSda & (sdaOe ? sdaOut : 1'h1);
   scbt_host h (.clk(clk), .sclWire(sclW), .sdaWire(sdaW), .scl(hScl), .sda(hSda));
   scbt_target #(.STRAP_WAIT_CYCLES(400), .CAPABILITIES(8'h3C)) dut (
      .clk(clk), .rst(rst), .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe),
      .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .addressStrapPin(strap),
      .modeStrapPin(mode), .rxLock(lock), .gpioIn(2'h2),
      .serializerAlias({7'h00, 7'h44}), .targetAlias('0), .rmtReq(rmtReq),
      .rmtReqValid(rmtReqValid), .rmtRsp(rmtRsp), .rmtRspValid(rmtRspValid),
      .bcRate(bcRate), .sideband(sideband));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (sclOe) sawStretch <= 1'h1;
      rmtRspValid <= (waitCnt == 1);
      if (waitCnt != 0) waitCnt <= waitCnt - 1;
      if (rmtReqValid && rmtReq.kind == RMT_STOP) sawStop <= 1'h1;
      else if (rmtReqValid) begin
         lastReq <= rmtReq;
         waitCnt <= 30;
      end
      if (cycles == 50000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_req(input scbt_rreq_t got, input scbt_rreq_t exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %0t: request %h expected %h", $time, got, exp);
      end
   endtask : chk_req
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] r, input logic [7:0] v);
      logic k;
      h.start();
      h.wr_byte({a, 1'h0}, k);
      h.wr_byte(r, k);
      h.wr_byte(v, k);
      h.stop();
      repeat (4) @(posedge clk);
   endtask : wr_reg
   task automatic rd_reg(input logic [6:0] a, input logic [7:0] r, output logic [7:0] v);
      logic k;
      h.start();
      h.wr_byte({a, 1'h0}, k);
      h.wr_byte(r, k);
      h.start();
      h.wr_byte({a, 1'h1}, k);
      h.rd_byte(1'h0, v);
      h.stop();
   endtask : rd_reg
   task automatic addr_only(input logic [7:0] a, input logic [7:0] exp);
      logic k;
      h.start();
      h.wr_byte(a, k);
      h.stop();
      chk(8'(k), exp);
   endtask : addr_only
   task automatic t_strap();
      logic [7:0] v;
      for (int i = 0; i < 2; i++) begin
         rst <= 1'h1;
         strap <= i ? 3'h7 : 3'h3;
         mode <= i[0];
         repeat (20) @(posedge clk);
         rst <= 1'h0;
         addr_only(i ? 8'h7A : 8'h6C, 8'h0);
         repeat (400) @(posedge clk);
         rd_reg(i ? 7'h3D : 7'h36, OFS_PRIMARY, v);
         chk(v, i ? 8'h7A : 8'h6C);
      end
      chk(8'(bcRate[1]), 8'(RATE_50M));
   endtask : t_strap
   task automatic t_local();
      logic [7:0] v;
      sawStretch <= 1'h0;
      wr_reg(7'h3D, OFS_GENCFG, 8'h20);
      chk(8'(sideband.proxyEn), 8'h1);
      chk(8'(sideband.gpio), 8'h2);
      chk(sideband.caps, 8'h3C);
      wr_reg(7'h3D, OFS_ALIAS0, 8'hA0);
      rd_reg(7'h50, OFS_PRIMARY, v);
      chk(v, 8'h7A);
      rd_reg(7'h50, OFS_ALIAS0, v);
      chk(v, 8'hA0);
      addr_only(8'h22, 8'h0);
      chk(8'(sawStretch), 8'h0);
   endtask : t_local
   task automatic t_remote();
      logic k;
      logic [7:0] v;
      wr_reg(7'h3D, OFS_PORTSEL, 8'h01);
      addr_only(8'h88, 8'h0);
      wr_reg(7'h3D, OFS_BCCFG, 8'h41);
      chk(8'(bcRate[0]), 8'(RATE_2P5M));
      sawStretch <= 1'h0;
      sawStop <= 1'h0;
      h.start();
      h.wr_byte(8'h88, k);
      chk(8'(k), 8'h1);
      chk_req(lastReq, '{RMT_ADDR, 1'h0, 1'h0, 8'h88});
      h.wr_byte(8'h3E, k);
      chk_req(lastReq, '{RMT_WRITE, 1'h0, 1'h0, 8'h3E});
      h.start();
      h.wr_byte(8'h89, k);
      chk_req(lastReq, '{RMT_ADDR, 1'h0, 1'h1, 8'h89});
      h.rd_byte(1'h0, v);
      chk(v, 8'hA5);
      h.stop();
      repeat (8) @(posedge clk);
      chk(8'({sawStretch, sawStop}), 8'h3);
      rmtRsp.ack <= 1'h0;
      addr_only(8'h88, 8'h0);
      rmtRsp.ack <= 1'h1;
      addr_only(8'h8A, 8'h0);
      lock <= 2'h2;
      addr_only(8'h88, 8'h0);
   endtask : t_remote
   task automatic tally_and_finish();
      if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   initial begin
      rst = 1'h1;
      strap = 3'h0;
      mode = 1'h0;
      rmtRsp = '{1'h1, 8'hA5};
      lock = 2'h3;
      {sawStretch, sawStop, rmtRspValid} = 3'h0;
      lastReq = '0;
      t_strap();
      t_local();
      t_remote();
      tally_and_finish();
   end
endmodule : serial_control_bus_target_tb
